// ==== design/msi_source_id_mapper.sv ====
// msi source identifier mapper: stream and device identifier derivation
`timescale 1ns/10ps
module msi_source_id_mapper (
  // clock and reset
  input  wire logic                               i_clk,
  input  wire logic                               i_rst_b,
  // initialization-time configuration, write only
  input  wire logic                               i_cfg_we,
  input  wire logic [msi_map_pkg::SEL_W-1:0]      i_cfg_sel,
  input  wire logic [msi_map_pkg::DEV_W-1:0]      i_cfg_data,
  input  wire logic                               i_init_done,
  // msi write request
  input  wire logic                               i_req_valid,
  input  wire logic [2:0]                         i_req_kind,
  input  wire logic [msi_map_pkg::RID_W-1:0]      i_req_requester_id,
  input  wire logic [msi_map_pkg::STREAM_W-1:0]   i_req_stream_id,
  input  wire logic [msi_map_pkg::DEV_W-1:0]      i_req_direct_id,
  input  wire logic [msi_map_pkg::GROUP_W-1:0]    i_req_src_group,
  input  wire logic [msi_map_pkg::GROUP_W-1:0]    i_req_dst_group,
  input  wire logic [msi_map_pkg::DATA_W-1:0]     i_req_data,
  // translation unit output
  output logic                                    o_atu_stream_valid,
  output logic      [msi_map_pkg::STREAM_W-1:0]   o_atu_stream_id,
  // msi towards the interrupt translation unit
  output logic                                    o_msi_valid,
  output logic      [msi_map_pkg::DEV_W-1:0]      o_msi_device_id,
  output logic      [msi_map_pkg::DATA_W-1:0]     o_msi_data,
  // write completion towards the master
  output logic                                    o_wr_done,
  output logic                                    o_wr_abort,
  output logic                                    o_wr_illegal,
  // status
  output logic                                    o_cfg_locked
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  msi_map_pkg::cfg_state_e                 cfg_state_r;
  logic                                    locked;
  logic [msi_map_pkg::DEV_W-1:0]           ofs_a;
  logic [msi_map_pkg::B_W-1:0]             ofs_b;
  logic [msi_map_pkg::DEV_W-1:0]           ofs_c;
  logic [msi_map_pkg::MODE_W-1:0]          mode_q;
  logic                                    we_a;
  logic                                    we_b;
  logic                                    we_c;
  logic                                    we_m;

  logic [msi_map_pkg::STREAM_W-1:0]        rid_ext;
  logic [msi_map_pkg::STREAM_W-1:0]        rc_base;
  logic [msi_map_pkg::STREAM_W-1:0]        rc_stream;
  logic [msi_map_pkg::STREAM_W-1:0]        stream_nxt;
  logic                                    illegal_nxt;
  logic                                    behind_atu_nxt;

  logic                                    s1_valid_r;
  msi_map_pkg::src_kind_e                  s1_kind_r;
  logic                                    s1_illegal_r;
  logic                                    s1_atu_r;
  logic [msi_map_pkg::STREAM_W-1:0]        s1_stream_r;
  logic [msi_map_pkg::DEV_W-1:0]           s1_rid_ext_r;
  logic [msi_map_pkg::DEV_W-1:0]           s1_direct_r;
  logic [msi_map_pkg::DATA_W-1:0]          s1_data_r;

  logic [msi_map_pkg::DEV_W-1:0]           atu_dev_id;
  logic [msi_map_pkg::DEV_W-1:0]           rc_dev_id;
  logic [msi_map_pkg::DEV_W-1:0]           legal_id;
  logic                                    clash;
  logic                                    send_msi_nxt;
  logic                                    done_nxt;
  logic                                    abort_nxt;
  logic [msi_map_pkg::DEV_W-1:0]           out_id_nxt;

  // ----------------------------------------------------------------
  // configuration lock
  // ----------------------------------------------------------------

  // lock closes at end of init and holds until reset
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cfg_state_r <= msi_map_pkg::CFG_OPEN;
    end else begin
      case (cfg_state_r)
        msi_map_pkg::CFG_OPEN: begin
          if (i_init_done) begin
            cfg_state_r <= msi_map_pkg::CFG_LOCKED;
          end
        end
        msi_map_pkg::CFG_LOCKED: begin
          cfg_state_r <= msi_map_pkg::CFG_LOCKED;
        end
        default: begin
          cfg_state_r <= msi_map_pkg::CFG_LOCKED;
        end
      endcase
    end
  end

  assign locked = (cfg_state_r != msi_map_pkg::CFG_OPEN);

  // status flop for software-free observation of the lock
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_cfg_locked <= 1'b0;
    end else begin
      o_cfg_locked <= locked;
    end
  end

  // ----------------------------------------------------------------
  // configuration storage, write only, nothing reads it back
  // ----------------------------------------------------------------

  // select decode; no readback path exists
  assign we_a = i_cfg_we && (i_cfg_sel == msi_map_pkg::CFG_SEL_OFS_A);
  assign we_b = i_cfg_we && (i_cfg_sel == msi_map_pkg::CFG_SEL_OFS_B);
  assign we_c = i_cfg_we && (i_cfg_sel == msi_map_pkg::CFG_SEL_OFS_C);
  assign we_m = i_cfg_we && (i_cfg_sel == msi_map_pkg::CFG_SEL_MODE);

  // offset added to every stream identifier
  cfg_lock_reg #(
    .W   (msi_map_pkg::DEV_W),
    .RST (msi_map_pkg::OFS_A_RST)
  ) u_ofs_a (
    .i_clk    (i_clk),
    .i_rst_b  (i_rst_b),
    .i_we     (we_a),
    .i_locked (locked),
    .i_data   (i_cfg_data),
    .o_q      (ofs_a)
  );

  // root complex stream base, scaled by two to the n
  cfg_lock_reg #(
    .W   (msi_map_pkg::B_W),
    .RST (msi_map_pkg::OFS_B_RST)
  ) u_ofs_b (
    .i_clk    (i_clk),
    .i_rst_b  (i_rst_b),
    .i_we     (we_b),
    .i_locked (locked),
    .i_data   (i_cfg_data[msi_map_pkg::B_W-1:0]),
    .o_q      (ofs_b)
  );

  // offset for a root complex with no translation unit
  cfg_lock_reg #(
    .W   (msi_map_pkg::DEV_W),
    .RST (msi_map_pkg::OFS_C_RST)
  ) u_ofs_c (
    .i_clk    (i_clk),
    .i_rst_b  (i_rst_b),
    .i_we     (we_c),
    .i_locked (locked),
    .i_data   (i_cfg_data),
    .o_q      (ofs_c)
  );

  // policy for illegal writes
  cfg_lock_reg #(
    .W   (msi_map_pkg::MODE_W),
    .RST (msi_map_pkg::MODE_RST)
  ) u_mode (
    .i_clk    (i_clk),
    .i_rst_b  (i_rst_b),
    .i_we     (we_m),
    .i_locked (locked),
    .i_data   (i_cfg_data[msi_map_pkg::MODE_W-1:0]),
    .o_q      (mode_q)
  );

  // ----------------------------------------------------------------
  // stage 1: classify and form the stream identifier
  // ----------------------------------------------------------------

  // full 16-bit requester space is mapped, hot-plug included
  assign rid_ext = {{msi_map_pkg::B_W{1'b0}}, i_req_requester_id};
  assign rc_base = {ofs_b, msi_map_pkg::RID_ZERO};

  // zero-extended requester id plus base times two to the n
  id_offset_adder #(
    .W (msi_map_pkg::STREAM_W)
  ) u_rc_stream (
    .i_base   (rid_ext),
    .i_offset (rc_base),
    .o_sum    (rc_stream)
  );

  // legality check and stream selection
  always_comb begin
    stream_nxt     = i_req_stream_id;
    illegal_nxt    = 1'b0;
    behind_atu_nxt = 1'b0;
    case (i_req_kind)
      msi_map_pkg::SRC_PE: begin
        illegal_nxt = 1'b1;
      end
      msi_map_pkg::SRC_UNTRUSTED: begin
        illegal_nxt = 1'b1;
      end
      msi_map_pkg::SRC_TRUSTED: begin
        illegal_nxt = 1'b0;
      end
      msi_map_pkg::SRC_ATU_DEV: begin
        behind_atu_nxt = 1'b1;
        stream_nxt     = i_req_stream_id;
      end
      msi_map_pkg::SRC_RC_ATU: begin
        behind_atu_nxt = 1'b1;
        stream_nxt     = rc_stream;
      end
      msi_map_pkg::SRC_RC_DIRECT: begin
        illegal_nxt = 1'b0;
      end
      default: begin
        illegal_nxt = 1'b1;
      end
    endcase
    // wrong group never reaches the translation unit
    if (i_req_src_group != i_req_dst_group) begin
      illegal_nxt = 1'b1;
    end
  end

  // stage 1 valid
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s1_valid_r <= 1'b0;
    end else begin
      s1_valid_r <= i_req_valid;
    end
  end

  // stage 1 classification
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s1_kind_r    <= msi_map_pkg::SRC_PE;
      s1_illegal_r <= 1'b0;
      s1_atu_r     <= 1'b0;
    end else if (i_req_valid) begin
      s1_kind_r    <= msi_map_pkg::src_kind_e'(i_req_kind);
      s1_illegal_r <= illegal_nxt;
      s1_atu_r     <= behind_atu_nxt;
    end
  end

  // stage 1 identifiers and payload
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s1_stream_r  <= '0;
      s1_rid_ext_r <= '0;
      s1_direct_r  <= '0;
      s1_data_r    <= '0;
    end else if (i_req_valid) begin
      s1_stream_r  <= stream_nxt;
      s1_rid_ext_r <= rid_ext;
      s1_direct_r  <= i_req_direct_id;
      s1_data_r    <= i_req_data;
    end
  end

  // ----------------------------------------------------------------
  // stage 2: device identifier and outcome
  // ----------------------------------------------------------------

  // stream identifier plus fixed offset, bijective
  id_offset_adder #(
    .W (msi_map_pkg::DEV_W)
  ) u_atu_dev (
    .i_base   (s1_stream_r),
    .i_offset (ofs_a),
    .o_sum    (atu_dev_id)
  );

  // direct root complex: requester id plus offset
  id_offset_adder #(
    .W (msi_map_pkg::DEV_W)
  ) u_rc_dev (
    .i_base   (s1_rid_ext_r),
    .i_offset (ofs_c),
    .o_sum    (rc_dev_id)
  );

  // pick the identifier for a legal source
  always_comb begin
    case (s1_kind_r)
      msi_map_pkg::SRC_ATU_DEV: legal_id = atu_dev_id;
      msi_map_pkg::SRC_RC_ATU:  legal_id = atu_dev_id;
      msi_map_pkg::SRC_RC_DIRECT: legal_id = rc_dev_id;
      msi_map_pkg::SRC_TRUSTED: legal_id = s1_direct_r;
      default:                  legal_id = msi_map_pkg::ALIAS_FREE_ID;
    endcase
  end

  // a legal id landing on the reserved value is refused
  assign clash = (legal_id == msi_map_pkg::ALIAS_FREE_ID);

  // outcome: msi, ignored completion or abort
  always_comb begin
    send_msi_nxt = 1'b0;
    done_nxt     = 1'b0;
    abort_nxt    = 1'b0;
    out_id_nxt   = legal_id;
    if (s1_illegal_r) begin
      case (mode_q)
        msi_map_pkg::ILL_WRITE_IGNORED: begin
          done_nxt = 1'b1;
        end
        msi_map_pkg::ILL_ABORT: begin
          abort_nxt = 1'b1;
        end
        msi_map_pkg::ILL_ALIAS_FREE: begin
          send_msi_nxt = 1'b1;
          done_nxt     = 1'b1;
          out_id_nxt   = msi_map_pkg::ALIAS_FREE_ID;
        end
        default: begin
          abort_nxt = 1'b1;
        end
      endcase
    end else if (clash) begin
      abort_nxt = 1'b1;
    end else begin
      send_msi_nxt = 1'b1;
      done_nxt     = 1'b1;
    end
  end

  // outcome pulses, one cycle per request
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_msi_valid  <= 1'b0;
      o_wr_done    <= 1'b0;
      o_wr_abort   <= 1'b0;
      o_wr_illegal <= 1'b0;
    end else begin
      o_msi_valid  <= s1_valid_r && send_msi_nxt;
      o_wr_done    <= s1_valid_r && done_nxt;
      o_wr_abort   <= s1_valid_r && abort_nxt;
      o_wr_illegal <= s1_valid_r && s1_illegal_r;
    end
  end

  // identifier travels beside its msi payload
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_msi_device_id <= '0;
      o_msi_data      <= '0;
    end else if (s1_valid_r) begin
      o_msi_device_id <= out_id_nxt;
      o_msi_data      <= s1_data_r;
    end
  end

  // stream identifier as seen after the translation unit
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_atu_stream_valid <= 1'b0;
      o_atu_stream_id    <= '0;
    end else begin
      o_atu_stream_valid <= s1_valid_r && s1_atu_r && !s1_illegal_r;
      if (s1_valid_r && s1_atu_r) begin
        o_atu_stream_id <= s1_stream_r;
      end
    end
  end

endmodule

// ==== design/msi_map_pkg.sv ====
// constants and types for the msi source identifier mapper
//
// Behaviour
// - every msi master gets a device identifier
// - processor or untrusted writes are illegal, never impersonate
// - msi outside own group is illegal
// - illegal: ignore, abort, or alias-free identifier
// - translation unit forwards stream identifier unchanged
// - stream to device mapping is one-to-one
// - device id is stream id plus offset
// - root complex stream id from requester id
// - requester id field is sixteen bits wide
// - direct root complex uses identity or offset
// - mapping frozen after initialization, no driver setup
// - device identifiers unique within group
// - no discovery interface is exposed
// - whole requester space reserved for hot-plug
package msi_map_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int RID_W    = 16;   // requester id field width n
  localparam int STREAM_W = 32;   // stream identifier width
  localparam int DEV_W    = 32;   // device identifier width
  localparam int B_W      = STREAM_W - RID_W;
  localparam int GROUP_W  = 4;    // translation unit group number
  localparam int DATA_W   = 32;   // msi payload width
  localparam int SEL_W    = 2;
  localparam int MODE_W   = 2;

  // ----------------------------------------------------------------
  // configuration selectors
  // ----------------------------------------------------------------
  localparam logic [SEL_W-1:0] CFG_SEL_OFS_A = 2'h0; // stream to device
  localparam logic [SEL_W-1:0] CFG_SEL_OFS_B = 2'h1; // rc stream base
  localparam logic [SEL_W-1:0] CFG_SEL_OFS_C = 2'h2; // direct rc offset
  localparam logic [SEL_W-1:0] CFG_SEL_MODE  = 2'h3; // illegal policy

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [DEV_W-1:0]  OFS_A_RST = 32'h0000_0000;
  localparam logic [B_W-1:0]    OFS_B_RST = 16'h0000;
  localparam logic [DEV_W-1:0]  OFS_C_RST = 32'h0000_0000;
  localparam logic [MODE_W-1:0] MODE_RST  = 2'h0;
  localparam logic [RID_W-1:0]  RID_ZERO  = 16'h0000;

  // identifier that no legitimate source may carry
  localparam logic [DEV_W-1:0] ALIAS_FREE_ID = 32'hFFFF_FFFF;

  // ----------------------------------------------------------------
  // enumerations
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SRC_PE        = 3'h0,  // processing element
    SRC_UNTRUSTED = 3'h1,  // master with no genuine msi support
    SRC_TRUSTED   = 3'h2,  // direct master, identifier given
    SRC_ATU_DEV   = 3'h3,  // master behind translation unit
    SRC_RC_ATU    = 3'h4,  // root complex behind translation unit
    SRC_RC_DIRECT = 3'h5   // root complex without translation unit
  } src_kind_e;

  typedef enum logic [MODE_W-1:0] {
    ILL_WRITE_IGNORED = 2'h0,
    ILL_ABORT         = 2'h1,
    ILL_ALIAS_FREE    = 2'h2
  } ill_mode_e;

  // gray-coded configuration lock
  typedef enum logic [1:0] {
    CFG_OPEN   = 2'b00,
    CFG_LOCKED = 2'b01
  } cfg_state_e;

endpackage

// ==== design/id_offset_adder.sv ====
// unsigned identifier plus offset, modulo the identifier width
`timescale 1ns/10ps
module id_offset_adder #(
  parameter int W = 32
) (
  // operands
  input  wire logic [W-1:0] i_base,
  input  wire logic [W-1:0] i_offset,
  // result
  output logic      [W-1:0] o_sum
);

  // modular add is a bijection for a fixed offset
  assign o_sum = i_base + i_offset;

endmodule

// ==== design/cfg_lock_reg.sv ====
// configuration word writable only until the lock closes
`timescale 1ns/10ps
module cfg_lock_reg #(
  parameter int           W   = 32,
  parameter logic [W-1:0] RST = '0
) (
  // clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_rst_b,
  // write side
  input  wire logic         i_we,
  input  wire logic         i_locked,
  input  wire logic [W-1:0] i_data,
  // stored value
  output logic      [W-1:0] o_q
);

  // writes after the lock closes are dropped
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_q <= RST;
    end else if (i_we && !i_locked) begin
      o_q <= i_data;
    end
  end

endmodule

// ==== sim/msi_source_id_mapper_properties.sv ====
// port-level assertions for the msi source identifier mapper
`timescale 1ns/10ps
module msi_source_id_mapper_properties (
  // clock and reset
  input wire logic        i_clk,
  input wire logic        i_rst_b,
  // configuration
  input wire logic        i_cfg_we,
  input wire logic [1:0]  i_cfg_sel,
  input wire logic [31:0] i_cfg_data,
  input wire logic        i_init_done,
  // request
  input wire logic        i_req_valid,
  input wire logic [2:0]  i_req_kind,
  input wire logic [15:0] i_req_requester_id,
  input wire logic [31:0] i_req_stream_id,
  input wire logic [3:0]  i_req_src_group,
  input wire logic [3:0]  i_req_dst_group,
  // results
  input wire logic        o_atu_stream_valid,
  input wire logic [31:0] o_atu_stream_id,
  input wire logic        o_msi_valid,
  input wire logic [31:0] o_msi_device_id,
  input wire logic        o_wr_done,
  input wire logic        o_wr_abort,
  input wire logic        o_wr_illegal,
  input wire logic        o_cfg_locked
);
  // ----------------
  // helper state
  // ----------------
  logic        lock_r;
  logic [31:0] ofs_a_r;
  logic [31:0] ofs_c_r;
  logic        ill;

  // request classed illegal by source kind or group
  assign ill = i_req_kind < 3'h2 || i_req_kind > 3'h5 ||
               i_req_src_group != i_req_dst_group;

  // lock closes on the edge that takes init done
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      lock_r <= 1'b0;
    end else if (i_init_done) begin
      lock_r <= 1'b1;
    end
  end

  // offsets as the design should hold them
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ofs_a_r <= 32'h0;
      ofs_c_r <= 32'h0;
    end else if (i_cfg_we && !lock_r) begin
      if (i_cfg_sel == 2'h0) ofs_a_r <= i_cfg_data;
      if (i_cfg_sel == 2'h2) ofs_c_r <= i_cfg_data;
    end
  end

  // ----------------
  // properties
  // ----------------
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_b);

  sequence s_legal(logic [2:0] k);
    i_req_valid && !ill && i_req_kind == k;
  endsequence
  sequence s_answer;
    ##2 (o_wr_done ^ o_wr_abort);
  endsequence

  a_fixed_latency: assert property (i_req_valid |-> s_answer)
    else $error("request not answered after two cycles");
  a_no_spurious: assert property (!i_req_valid |-> ##2 !(o_wr_done ||
    o_wr_abort || o_msi_valid || o_wr_illegal))
    else $error("completion without a request");
  a_illegal_flag: assert property (i_req_valid && ill |->
    ##2 o_wr_illegal && !o_atu_stream_valid)
    else $error("illegal write not flagged");
  a_illegal_alias: assert property (o_msi_valid && o_wr_illegal |->
    o_msi_device_id == 32'hFFFF_FFFF)
    else $error("illegal msi carries a real identifier");
  a_legal_no_alias: assert property (o_msi_valid && !o_wr_illegal |->
    o_msi_device_id != 32'hFFFF_FFFF && o_wr_done)
    else $error("legal msi carries the reserved identifier");
  a_stream_echo: assert property (s_legal(3'h3) |-> ##2
    o_atu_stream_valid && o_atu_stream_id == $past(i_req_stream_id, 2) &&
    (o_wr_abort || o_msi_device_id ==
     $past(i_req_stream_id, 2) + $past(ofs_a_r, 2)))
    else $error("stream echo or offset wrong");
  a_rc_stream: assert property (s_legal(3'h4) |-> ##2
    o_atu_stream_valid && o_atu_stream_id[15:0] ==
    $past(i_req_requester_id, 2))
    else $error("root complex stream low bits wrong");
  a_rc_direct: assert property (s_legal(3'h5) |-> ##2 o_wr_abort ||
    o_msi_device_id == {16'h0, $past(i_req_requester_id, 2)} +
    $past(ofs_c_r, 2))
    else $error("direct root complex identifier wrong");
  a_lock_closes: assert property (i_init_done |-> ##2 o_cfg_locked)
    else $error("lock did not close");
  a_lock_holds: assert property (o_cfg_locked |=> o_cfg_locked)
    else $error("lock reopened without reset");
  a_lock_cause: assert property ($rose(o_cfg_locked) |->
    $past(i_init_done, 2))
    else $error("lock closed without init done");
endmodule

// ==== sim/irq_translator_model.sv ====
// interrupt translator stand-in that counts delivered messages
`timescale 1ns/10ps
module irq_translator_model (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst_b,
  // message from the mapper
  input  wire logic        i_msi_valid,
  input  wire logic [31:0] i_msi_device_id,
  // delivered message count
  output int               o_count
);
  // count every delivered message
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_count <= 0;
    end else if (i_msi_valid) begin
      o_count <= o_count + 1;
    end
  end
endmodule

// ==== sim/msi_source_id_mapper_tb.sv ====
// self-checking bench for the msi source identifier mapper
`timescale 1ns/10ps
module msi_source_id_mapper_tb;
  logic        i_clk = 1'b0, i_rst_b = 1'b0, i_cfg_we = 1'b0;
  logic        i_init_done = 1'b0, i_req_valid = 1'b0;
  logic [1:0]  i_cfg_sel = 2'h0;
  logic [2:0]  i_req_kind = 3'h0;
  logic [3:0]  i_req_src_group = 4'h0, i_req_dst_group = 4'h0;
  logic [15:0] i_req_requester_id = 16'h0;
  logic [31:0] i_cfg_data = 32'h0, i_req_stream_id = 32'h0;
  logic [31:0] i_req_direct_id = 32'h0, i_req_data = 32'h0;
  logic        o_atu_stream_valid, o_msi_valid, o_wr_done, o_wr_abort;
  logic        o_wr_illegal, o_cfg_locked;
  logic [31:0] o_atu_stream_id, o_msi_device_id, o_msi_data;
  int          n_errors = 0, checks = 0, sink_count;
  typedef struct {
    logic [5:0]  fl;  // atu, msi, done, abort, illegal, locked
    logic [31:0] sid, did, data;
  } exp_s;
  exp_s        q[$];
  exp_s        e, r;
  int unsigned ofs_a, ofs_b, ofs_c, mode, n_msi, sid, id;
  bit          ill, lock;

  always #10 i_clk = ~i_clk;

  msi_source_id_mapper u_dut (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_cfg_we(i_cfg_we),
    .i_cfg_sel(i_cfg_sel), .i_cfg_data(i_cfg_data),
    .i_init_done(i_init_done), .i_req_valid(i_req_valid),
    .i_req_kind(i_req_kind), .i_req_requester_id(i_req_requester_id),
    .i_req_stream_id(i_req_stream_id), .i_req_direct_id(i_req_direct_id),
    .i_req_src_group(i_req_src_group), .i_req_dst_group(i_req_dst_group),
    .i_req_data(i_req_data), .o_atu_stream_valid(o_atu_stream_valid),
    .o_atu_stream_id(o_atu_stream_id), .o_msi_valid(o_msi_valid),
    .o_msi_device_id(o_msi_device_id), .o_msi_data(o_msi_data),
    .o_wr_done(o_wr_done), .o_wr_abort(o_wr_abort),
    .o_wr_illegal(o_wr_illegal), .o_cfg_locked(o_cfg_locked));

  irq_translator_model u_sink (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_msi_valid(o_msi_valid),
    .i_msi_device_id(o_msi_device_id), .o_count(sink_count));

  // ----------------
  // tasks
  // ----------------
  task automatic chk(input string nm, input logic [31:0] ex, got);
    checks++;
    if (got !== ex) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, ex, got);
    end
  endtask

  task automatic cfg(input logic we, input logic [1:0] sel,
                     input logic [31:0] d, input logic ini);
    @(posedge i_clk);
    i_req_valid <= 1'b0;
    i_cfg_we <= we;
    i_cfg_sel <= sel;
    i_cfg_data <= d;
    i_init_done <= ini;
  endtask

  task automatic req(input logic [2:0] k, input logic [15:0] rid,
                     input logic [31:0] s, dd, input logic [3:0] sg, dg);
    @(posedge i_clk);
    i_cfg_we <= 1'b0;
    i_init_done <= 1'b0;
    i_req_valid <= 1'b1;
    i_req_kind <= k;
    i_req_requester_id <= rid;
    i_req_stream_id <= s;
    i_req_direct_id <= dd;
    i_req_src_group <= sg;
    i_req_dst_group <= dg;
    i_req_data <= $urandom;
  endtask

  task automatic idle(input int n);
    repeat (n) begin
      @(posedge i_clk);
      i_req_valid <= 1'b0;
      i_cfg_we <= 1'b0;
      i_init_done <= 1'b0;
    end
  endtask

  task automatic conclude();
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ----------------
  // reference model, compared two samples later
  // ----------------
  always @(negedge i_clk) begin
    if (!i_rst_b) begin
      q.delete();
      {ofs_a, ofs_b, ofs_c, mode, n_msi, lock} = '0;
    end else begin
      e = '{default: '0};
      if (i_req_valid) begin
        ill = i_req_kind < 2 || i_req_kind > 5 ||
              i_req_src_group != i_req_dst_group;
        sid = (ofs_b << 16) + i_req_requester_id;
        if (i_req_kind == 3) sid = i_req_stream_id;
        id = sid + ofs_a;
        if (i_req_kind == 2) id = i_req_direct_id;
        if (i_req_kind == 5) id = i_req_requester_id + ofs_c;
        if (ill) begin
          e.fl = (mode == 2) ? 6'h1A : (mode == 0) ? 6'h0A : 6'h06;
          id = 32'hFFFF_FFFF;
        end else if (id == 32'hFFFF_FFFF) begin
          e.fl = 6'h04;
        end else begin
          e.fl = (i_req_kind == 3 || i_req_kind == 4) ? 6'h38 : 6'h18;
        end
        e.sid = sid;
        e.did = id;
        e.data = i_req_data;
        if (e.fl[4]) n_msi++;
      end
      if (i_cfg_we && !lock) begin
        case (i_cfg_sel)
          2'h0: ofs_a = i_cfg_data;
          2'h1: ofs_b = i_cfg_data[15:0];
          2'h2: ofs_c = i_cfg_data;
          default: mode = i_cfg_data[1:0];
        endcase
      end
      if (i_init_done) lock = 1'b1;
      e.fl[0] = lock;
      q.push_back(e);
      if (q.size() > 2) begin
        r = q.pop_front();
        chk("flags", {26'h0, r.fl}, {26'h0,
            o_atu_stream_valid, o_msi_valid, o_wr_done, o_wr_abort,
            o_wr_illegal, o_cfg_locked});
        if (r.fl[4]) chk("device_id", r.did,
                         o_msi_device_id);
        if (r.fl[4]) chk("msi_data", r.data, o_msi_data);
        if (r.fl[5]) chk("stream_id", r.sid,
                         o_atu_stream_id);
      end
    end
  end

  // bounded run length
  initial begin
    repeat (20000) @(posedge i_clk);
    n_errors++;
    conclude();
  end

  // ----------------
  // main sequence
  // ----------------
  initial begin
    void'($urandom(2203));
    repeat (16) @(posedge i_clk);
    i_rst_b <= 1'b1;
    cfg(1'b1, 2'h0, 32'h0000_0100, 1'b0);
    cfg(1'b1, 2'h1, 32'h0000_0002, 1'b0);
    cfg(1'b1, 2'h2, 32'h0000_4000, 1'b0);
    // every source kind back to back, top requester id
    for (int k = 0; k < 8; k++) begin
      req(3'(k), 16'hFFFF, 32'h0002_FFFF, 32'h77, 4'h1, 4'h1);
    end
    // every illegal policy, cross-group on even kinds
    for (int m = 0; m < 4; m++) begin
      cfg(1'b1, 2'h3, 32'(m), 1'b0);
      for (int k = 0; k < 8; k++) begin
        req(3'(k), 16'(k), 32'(k), 32'h10 + k, 4'h2,
            4'(3 - k % 2));
      end
      req(3'h2, 16'h0, 32'h0, 32'hFFFF_FFFF, 4'h0, 4'h0);
    end
    // lock with a write in the same cycle, then a refused write
    cfg(1'b1, 2'h3, 32'h2, 1'b1);
    cfg(1'b1, 2'h0, 32'h0000_0999, 1'b0);
    repeat (300) begin
      req(3'($urandom_range(7)), 16'($urandom), $urandom, $urandom,
          4'($urandom_range(1)), 4'($urandom_range(1)));
      if ($urandom_range(3) == 0) idle(1);
    end
    idle(4);
    chk("sink_count", n_msi, sink_count);
    // reset in mid-run clears offsets and lock
    @(posedge i_clk);
    i_rst_b <= 1'b0;
    idle(2);
    i_rst_b <= 1'b1;
    req(3'h3, 16'h0, 32'h0000_1234, 32'h0, 4'h5, 4'h5);
    req(3'h5, 16'hABCD, 32'h0, 32'h0, 4'h5, 4'h5);
    idle(4);
    chk("sink_count", n_msi, sink_count);
    conclude();
  end
endmodule

bind msi_source_id_mapper msi_source_id_mapper_properties u_props (
  .i_clk(i_clk), .i_rst_b(i_rst_b), .i_cfg_we(i_cfg_we),
  .i_cfg_sel(i_cfg_sel), .i_cfg_data(i_cfg_data),
  .i_init_done(i_init_done), .i_req_valid(i_req_valid),
  .i_req_kind(i_req_kind), .i_req_requester_id(i_req_requester_id),
  .i_req_stream_id(i_req_stream_id), .i_req_src_group(i_req_src_group),
  .i_req_dst_group(i_req_dst_group),
  .o_atu_stream_valid(o_atu_stream_valid),
  .o_atu_stream_id(o_atu_stream_id), .o_msi_valid(o_msi_valid),
  .o_msi_device_id(o_msi_device_id), .o_wr_done(o_wr_done),
  .o_wr_abort(o_wr_abort), .o_wr_illegal(o_wr_illegal),
  .o_cfg_locked(o_cfg_locked));
